// ---- core/asu_uart.sv ----
// uart-mode serial channel: apb registers, baud divider, transmitter, receiver
`timescale 1ns/1ps
`default_nettype none
module asu_uart (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [asu_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [asu_pkg::DATA_W-1:0]  pwdata,
  output var  logic [asu_pkg::DATA_W-1:0]  prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  input  wire logic                        serial_in_pin,
  output var  logic                        serial_out_pin,
  output var  logic                        serial_out_oe_n,
  input  wire logic                        ext_clock_pin,
  input  wire logic                        handshake_in,
  output var  logic                        handshake_out,
  output var  logic                        handshake_oe_n,
  output var  logic                        tx_irq,
  output var  logic                        rx_irq
);
  import asu_pkg::*;

  logic [7:0]          mode_q;
  logic [7:0]          baud_q;
  logic [7:0]          ctrl0_q;
  logic [7:0]          ctrl1_q;
  logic [CHAR_W-1:0]   tx_buf_q;
  logic                tx_empty_q;
  logic [CHAR_W-1:0]   rx_buf_q;
  logic                rx_full_q;
  logic                ovr_q;
  logic                fer_q;
  logic                per_q;
  logic                sum_q;
  logic [DATA_W-1:0]   rd_data;
  logic                hit;
  logic                wr_acc;
  logic                rd_acc;
  asu_tx_state_t       tx_state_q;
  asu_rx_state_t       rx_state_q;

  // ---------------- apb slave, no wait states; read data is registered in the setup cycle
  assign wr_acc = psel & penable & pready & pwrite;
  assign rd_acc = psel & penable & pready & ~pwrite;

  always_comb begin
    rd_data = '0;
    hit     = 1'b1;
    unique case (paddr)
      OFF_MODE:  rd_data[7:0] = mode_q;
      OFF_BAUD:  rd_data[7:0] = baud_q;
      OFF_CTRL0: begin
        rd_data[7:0]       = ctrl0_q;
        rd_data[C0_TX_IDLE] = (tx_state_q == TX_IDLE);
      end
      OFF_CTRL1: begin
        rd_data[7:0]      = ctrl1_q;
        rd_data[C1_TXBE]   = tx_empty_q;
        rd_data[C1_RXFULL] = rx_full_q;
      end
      OFF_TXBUF: rd_data[CHAR_W-1:0] = tx_buf_q;
      OFF_RXBUF: begin
        rd_data[CHAR_W-1:0] = rx_buf_q;
        rd_data[RB_OVR]     = ovr_q;
        rd_data[RB_FER]     = fer_q;
        rd_data[RB_PER]     = per_q;
        rd_data[RB_SUM]     = sum_q;
      end
      default:   hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (psel & ~penable & ~pwrite) begin
        prdata <= rd_data;
      end
    end
  end

  // status bits are stored separately, so their positions here are don't-care
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode_q  <= MODE_RST;
      baud_q  <= BAUD_RST;
      ctrl0_q <= CTRL0_RST;
      ctrl1_q <= CTRL1_RST;
    end else if (wr_acc) begin
      if (paddr == OFF_MODE)  mode_q  <= pwdata[7:0];
      if (paddr == OFF_BAUD)  baud_q  <= pwdata[7:0];
      if (paddr == OFF_CTRL0) ctrl0_q <= pwdata[7:0];
      if (paddr == OFF_CTRL1) ctrl1_q <= pwdata[7:0];
    end
  end

  // ---------------- frame format decode
  logic [3:0]        len_bits;
  logic [CHAR_W-1:0] len_mask;
  logic              msb_first;
  logic              par_en;
  logic              par_odd;
  logic              two_stop;
  logic              pin_pol;
  logic              data_inv;

  always_comb begin
    unique case (mode_q[MODE_LEN_HI:MODE_LEN_LO])
      LEN_7:   len_bits = BITS_7;
      LEN_9:   len_bits = BITS_9;
      default: len_bits = BITS_8;
    endcase
    len_mask = ~({CHAR_W{1'b1}} << len_bits);
  end

  assign msb_first = ctrl0_q[C0_MSB_FIRST] & (len_bits == BITS_8);
  assign par_en    = mode_q[MODE_PAR_EN];
  assign par_odd   = ~mode_q[MODE_PAR_EVEN];
  assign two_stop  = mode_q[MODE_STOP2];
  assign pin_pol   = mode_q[MODE_PINPOL];
  assign data_inv  = ctrl1_q[C1_INV];

  // maps buffer order to line order and back; same swap both ways
  function automatic logic [CHAR_W-1:0] order_bits(input logic [CHAR_W-1:0] v,
                                                   input logic msb);
    logic [CHAR_W-1:0] r;
    r = v;
    if (msb) begin
      for (int i = 0; i < 8; i++) r[i] = v[7-i];
    end
    return r;
  endfunction

  // ---------------- pin synchronisers and rx filter
  logic rx_sync;
  logic cts_sync;
  logic ext_sync;
  logic ext_prev_q;
  logic [2:0] filt_q;
  logic rx_filt_q;
  logic rx_in;

  asu_sync #(.RST_VAL(1'b1)) u_rx_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (serial_in_pin),
    .level    (rx_sync)
  );
  asu_sync #(.RST_VAL(1'b1)) u_cts_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (handshake_in),
    .level    (cts_sync)
  );
  asu_sync #(.RST_VAL(1'b0)) u_ext_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (ext_clock_pin),
    .level    (ext_sync)
  );

  // filter: a level passes only after three equal consecutive samples
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      filt_q    <= 3'h7;
      rx_filt_q <= 1'b1;
      ext_prev_q <= 1'b0;
    end else begin
      filt_q     <= {filt_q[1:0], rx_sync};
      ext_prev_q <= ext_sync;
      if (&filt_q || ~|filt_q) rx_filt_q <= filt_q[2];
    end
  end

  assign rx_in = (ctrl1_q[C1_FILT] ? rx_filt_q : rx_sync) ^ pin_pol;

  // ---------------- baud generation: source tick, then divider to 16x tick
  logic [4:0] presc_q;
  logic [4:0] presc_lim;
  logic       src_tick;
  logic [7:0] brg_q;
  logic       samp_tick_q;

  always_comb begin
    unique case (ctrl0_q[C0_PRESC_HI:C0_PRESC_LO])
      PRESC_F8:  presc_lim = PRESC_LIM8;
      PRESC_F32: presc_lim = PRESC_LIM32;
      default:   presc_lim = '0;
    endcase
  end

  assign src_tick = mode_q[MODE_CKSRC] ? (ext_sync & ~ext_prev_q)
                                       : (presc_q >= presc_lim);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      presc_q     <= '0;
      brg_q       <= '0;
      samp_tick_q <= 1'b0;
    end else begin
      presc_q     <= (presc_q >= presc_lim) ? '0 : presc_q + 5'h01;
      samp_tick_q <= 1'b0;
      if (src_tick) begin
        if (brg_q == '0) begin
          brg_q       <= baud_q;
          samp_tick_q <= 1'b1;
        end else begin
          brg_q <= brg_q - 8'h01;
        end
      end
    end
  end

  // ---------------- transmitter
  logic              cts_mode;
  logic              tx_go;
  logic [CHAR_W-1:0] tx_char;
  logic [CHAR_W-1:0] tx_sh_q;
  logic [3:0]        tx_tick_q;
  logic [3:0]        tx_cnt_q;
  logic              tx_par_q;
  logic              tx_line_q;
  logic              tx_done;

  assign cts_mode = ~ctrl0_q[C0_HS_DIS] & ~ctrl0_q[C0_HS_RTS];
  assign tx_go    = (tx_state_q == TX_IDLE) & ctrl1_q[C1_TE] & ~tx_empty_q
                    & (~cts_mode | ~cts_sync);
  assign tx_char  = order_bits((tx_buf_q ^ {CHAR_W{data_inv}}) & len_mask,
                               msb_first);
  assign tx_done  = samp_tick_q & (tx_state_q == TX_STOP) & (tx_tick_q == TICK_LAST)
                    & (tx_cnt_q == {3'h0, two_stop});

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_state_q <= TX_IDLE;
      tx_sh_q    <= '0;
      tx_tick_q  <= '0;
      tx_cnt_q   <= '0;
      tx_par_q   <= 1'b0;
      tx_line_q  <= 1'b1;
    end else if (tx_go) begin
      tx_state_q <= TX_START;
      tx_sh_q    <= tx_char;
      tx_par_q   <= (^tx_char) ^ par_odd;
      tx_tick_q  <= '0;
      tx_line_q  <= 1'b0;
    end else if (samp_tick_q && tx_state_q != TX_IDLE) begin
      tx_tick_q <= tx_tick_q + 4'h1;
      if (tx_tick_q == TICK_LAST) begin
        unique case (tx_state_q)
          TX_START: begin
            tx_state_q <= TX_DATA;
            tx_cnt_q   <= '0;
            tx_line_q  <= tx_sh_q[0];
            tx_sh_q    <= tx_sh_q >> 1;
          end
          TX_DATA: begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == len_bits - 4'h1) begin
              tx_state_q <= par_en ? TX_PAR : TX_STOP;
              tx_line_q  <= par_en ? tx_par_q : 1'b1;
              tx_cnt_q   <= '0;
            end else begin
              tx_line_q <= tx_sh_q[0];
              tx_sh_q   <= tx_sh_q >> 1;
            end
          end
          TX_PAR: begin
            tx_state_q <= TX_STOP;
            tx_line_q  <= 1'b1;
            tx_cnt_q   <= '0;
          end
          TX_STOP: begin
            if (tx_done) begin
              tx_state_q <= TX_IDLE;
            end else begin
              tx_cnt_q <= tx_cnt_q + 4'h1;
            end
          end
          default: tx_state_q <= TX_IDLE;
        endcase
      end
    end
  end

  // a write in the very cycle of a load leaves data present, not empty
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_buf_q   <= '0;
      tx_empty_q <= 1'b1;
    end else begin
      if (tx_go) tx_empty_q <= 1'b1;
      if (wr_acc && paddr == OFF_TXBUF) begin
        tx_buf_q   <= pwdata[CHAR_W-1:0] & len_mask;
        tx_empty_q <= 1'b0;
      end
    end
  end

  // ---------------- pins and request pulses
  logic rts_mode;
  assign rts_mode = ~ctrl0_q[C0_HS_DIS] & ctrl0_q[C0_HS_RTS];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      serial_out_pin  <= 1'b1;
      serial_out_oe_n <= 1'b1;
      handshake_out   <= 1'b1;
      handshake_oe_n  <= 1'b1;
      tx_irq          <= 1'b0;
    end else begin
      serial_out_pin  <= tx_line_q ^ pin_pol;
      // open drain only pulls low; idle high becomes released
      serial_out_oe_n <= ctrl0_q[C0_OPEN_DRAIN] & (tx_line_q ^ pin_pol);
      handshake_out   <= ~(ctrl1_q[C1_RE] & ~rx_full_q);
      handshake_oe_n  <= ~rts_mode;
      tx_irq          <= ctrl1_q[C1_IRS] ? tx_done : tx_go;
    end
  end

  // ---------------- receiver
  logic [CHAR_W-1:0] rx_sh_q;
  logic [3:0]        rx_tick_q;
  logic [3:0]        rx_cnt_q;
  logic              rx_par_q;
  logic              rx_stop_bad_q;
  logic              ovr_pend_q;
  logic              rx_done_q;
  logic              rx_mid;
  logic [CHAR_W-1:0] rx_line_char;
  logic [CHAR_W-1:0] rx_char;
  logic              par_bad;

  assign rx_mid = samp_tick_q & (rx_tick_q == TICK_LAST);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_state_q    <= RX_IDLE;
      rx_sh_q       <= '0;
      rx_tick_q     <= '0;
      rx_cnt_q      <= '0;
      rx_par_q      <= 1'b0;
      rx_stop_bad_q <= 1'b0;
      ovr_pend_q    <= 1'b0;
      rx_done_q     <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (samp_tick_q) begin
        rx_tick_q <= rx_tick_q + 4'h1;
      end
      unique case (rx_state_q)
        RX_IDLE: begin
          if (samp_tick_q && ctrl1_q[C1_RE] && !rx_in) begin
            rx_state_q    <= RX_START;
            rx_tick_q     <= '0;
            rx_stop_bad_q <= 1'b0;
            ovr_pend_q    <= 1'b0;
          end
        end
        RX_START: begin
          if (samp_tick_q && rx_tick_q == TICK_MID) begin
            // a glitch shorter than half a bit is dropped here
            rx_state_q <= rx_in ? RX_IDLE : RX_DATA;
            rx_tick_q  <= '0;
            rx_cnt_q   <= '0;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_sh_q  <= {rx_in, rx_sh_q[CHAR_W-1:1]};
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == len_bits - 4'h1) begin
              rx_state_q <= par_en ? RX_PAR : RX_STOP;
              rx_cnt_q   <= '0;
              if (!par_en && !two_stop) ovr_pend_q <= rx_full_q;
            end
          end
        end
        RX_PAR: begin
          if (rx_mid) begin
            rx_par_q   <= rx_in;
            rx_state_q <= RX_STOP;
            rx_cnt_q   <= '0;
            if (!two_stop) ovr_pend_q <= rx_full_q;
          end
        end
        RX_STOP: begin
          if (rx_mid) begin
            if (!rx_in) rx_stop_bad_q <= 1'b1;
            if (rx_cnt_q == {3'h0, two_stop}) begin
              rx_state_q <= RX_IDLE;
              rx_done_q  <= 1'b1;
            end else begin
              rx_cnt_q   <= rx_cnt_q + 4'h1;
              ovr_pend_q <= rx_full_q;
            end
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  assign rx_line_char = (rx_sh_q >> (CHAR_W - len_bits)) & len_mask;
  assign rx_char      = order_bits(rx_line_char ^ ({CHAR_W{data_inv}} & len_mask),
                                   msb_first);
  assign par_bad      = par_en & ((^rx_line_char) ^ rx_par_q ^ par_odd);

  // error flags clear on a write to the rx buffer; a new error wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_buf_q  <= '0;
      rx_full_q <= 1'b0;
      ovr_q     <= 1'b0;
      fer_q     <= 1'b0;
      per_q     <= 1'b0;
      sum_q     <= 1'b0;
      rx_irq    <= 1'b0;
    end else begin
      rx_irq <= 1'b0;
      if (rd_acc && paddr == OFF_RXBUF) rx_full_q <= 1'b0;
      if (wr_acc && paddr == OFF_RXBUF) begin
        ovr_q <= 1'b0;
        fer_q <= 1'b0;
        per_q <= 1'b0;
        sum_q <= 1'b0;
      end
      if (rx_done_q) begin
        fer_q <= rx_stop_bad_q | (fer_q & ~(wr_acc && paddr == OFF_RXBUF));
        per_q <= par_bad | (per_q & ~(wr_acc && paddr == OFF_RXBUF));
        if (ovr_pend_q) begin
          ovr_q <= 1'b1;
        end else begin
          rx_buf_q  <= rx_char;
          rx_full_q <= 1'b1;
          rx_irq    <= 1'b1;
        end
        if (ovr_pend_q || rx_stop_bad_q || par_bad) sum_q <= 1'b1;
      end
    end
  end

  // ---------------- assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_tx_start_cond;
    $rose(tx_state_q == TX_START) |->
      $past(ctrl1_q[C1_TE] && !tx_empty_q && (!cts_mode || !cts_sync));
  endproperty
  a_tx_start_cond: assert property (p_tx_start_cond) else $error("tx start without enable");

  property p_tx_irq_load;
    (tx_go && !ctrl1_q[C1_IRS]) |=> tx_irq ##1 !tx_irq;
  endproperty
  a_tx_irq_load: assert property (p_tx_irq_load) else $error("tx irq missing at load");

  property p_tx_irq_done;
    (tx_done && ctrl1_q[C1_IRS]) |=> tx_irq && tx_state_q == TX_IDLE;
  endproperty
  a_tx_irq_done: assert property (p_tx_irq_done) else $error("tx irq missing at end");

  property p_rx_irq_load;
    rx_irq |-> rx_full_q && $past(rx_done_q) && !$past(ovr_pend_q);
  endproperty
  a_rx_irq_load: assert property (p_rx_irq_load) else $error("rx irq without transfer");

  property p_ovr_no_irq;
    (rx_done_q && ovr_pend_q) |=> !rx_irq && ovr_q && sum_q && $stable(rx_buf_q);
  endproperty
  a_ovr_no_irq: assert property (p_ovr_no_irq) else $error("overrun touched rx irq");

  property p_fer_at_load;
    (rx_done_q && rx_stop_bad_q) |=> fer_q && sum_q;
  endproperty
  a_fer_at_load: assert property (p_fer_at_load) else $error("framing flag not set");

  property p_sum_covers;
    (ovr_q || fer_q || per_q) |-> sum_q;
  endproperty
  a_sum_covers: assert property (p_sum_covers) else $error("error sum clear");

  property p_rx_start_en;
    $rose(rx_state_q == RX_START) |-> $past(ctrl1_q[C1_RE]) && $past(!rx_in);
  endproperty
  a_rx_start_en: assert property (p_rx_start_en) else $error("rx start without enable");

  property p_tx_idle_line;
    (tx_state_q == TX_IDLE && $past(tx_state_q == TX_IDLE) && $stable(mode_q)) |=>
      (serial_out_pin == !$past(pin_pol)) && (serial_out_oe_n == $past(ctrl0_q[C0_OPEN_DRAIN]));
  endproperty
  a_tx_idle_line: assert property (p_tx_idle_line) else $error("tx line not idle");

  property p_start_bit_low;
    $rose(tx_state_q == TX_START) |=> serial_out_pin == pin_pol;
  endproperty
  a_start_bit_low: assert property (p_start_bit_low) else $error("start bit level");

  c_tx_done: cover property (tx_done);
  c_rx_load: cover property (rx_irq);
  c_overrun: cover property (rx_done_q && ovr_pend_q);
  c_par_err: cover property (rx_done_q && par_bad);
endmodule
`default_nettype wire

// ---- core/asu_pkg.sv ----
// constants, register map and state types of the asynchronous serial channel
package asu_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CHAR_W = 9;

  localparam logic [ADDR_W-1:0] OFF_MODE  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_BAUD  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CTRL1 = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_TXBUF = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_RXBUF = 8'h14;

  // channel_mode_reg fields
  localparam int unsigned MODE_LEN_LO   = 0;
  localparam int unsigned MODE_LEN_HI   = 2;
  localparam int unsigned MODE_CKSRC    = 3;
  localparam int unsigned MODE_STOP2    = 4;
  localparam int unsigned MODE_PAR_EVEN = 5;
  localparam int unsigned MODE_PAR_EN   = 6;
  localparam int unsigned MODE_PINPOL   = 7;
  // channel_control_zero fields
  localparam int unsigned C0_PRESC_LO   = 0;
  localparam int unsigned C0_PRESC_HI   = 1;
  localparam int unsigned C0_HS_RTS     = 2;
  localparam int unsigned C0_TX_IDLE    = 3;
  localparam int unsigned C0_HS_DIS     = 4;
  localparam int unsigned C0_OPEN_DRAIN = 5;
  localparam int unsigned C0_MSB_FIRST  = 7;
  // channel_control_one fields
  localparam int unsigned C1_TE         = 0;
  localparam int unsigned C1_TXBE       = 1;
  localparam int unsigned C1_RE         = 2;
  localparam int unsigned C1_RXFULL     = 3;
  localparam int unsigned C1_IRS        = 4;
  localparam int unsigned C1_INV        = 6;
  localparam int unsigned C1_FILT       = 7;
  // rx_buffer error fields
  localparam int unsigned RB_OVR        = 12;
  localparam int unsigned RB_FER        = 13;
  localparam int unsigned RB_PER        = 14;
  localparam int unsigned RB_SUM        = 15;

  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST  = 8'h00;
  localparam logic [7:0] CTRL0_RST = 8'h10;
  localparam logic [7:0] CTRL1_RST = 8'h00;

  localparam logic [2:0] LEN_7 = 3'h4;
  localparam logic [2:0] LEN_8 = 3'h5;
  localparam logic [2:0] LEN_9 = 3'h6;
  localparam logic [3:0] BITS_7 = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;

  localparam logic [1:0] PRESC_F8  = 2'h1;
  localparam logic [1:0] PRESC_F32 = 2'h2;
  localparam logic [4:0] PRESC_LIM8  = 5'h07;
  localparam logic [4:0] PRESC_LIM32 = 5'h1f;

  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID  = 4'h7;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_START = 3'h1,
    TX_DATA  = 3'h2,
    TX_PAR   = 3'h3,
    TX_STOP  = 3'h4
  } asu_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'h0,
    RX_START = 3'h1,
    RX_DATA  = 3'h2,
    RX_PAR   = 3'h3,
    RX_STOP  = 3'h4
  } asu_rx_state_t;
endpackage

// ---- core/asu_sync.sv ----
// three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module asu_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic pin,
  output var  logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      level <= RST_VAL;
    end else if (s2_q == s3_q) begin
      level <= s3_q;
    end
  end
endmodule
`default_nettype wire

// ---- dv/asu_remote.sv ----
// remote serial transceiver on the line, one bit every 16 core clocks
`timescale 1ns/1ps
`default_nettype none
module asu_remote (
  input  wire logic core_clk,
  input  wire logic tx_line,
  output var  logic rx_line
);
  initial rx_line = 1'b1;
  // frame bits go out lsb first, start bit included; line idles high after
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      rx_line <= bits[i];
      repeat (15) @(posedge core_clk);
    end
    @(posedge core_clk);
    rx_line <= 1'b1;
  endtask
  // sample mid-bit, so a first bit shortened by one tick is still caught
  task automatic listen(input int n, output logic [15:0] bits);
    bits = '0;
    wait (tx_line === 1'b0);
    repeat (8) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = tx_line;
      repeat (16) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/asu_uart_bench.sv ----
// self-checking bench of the uart-mode serial channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %h want %h", $time, a, b); end end
module asu_uart_bench;
  import asu_pkg::*;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, last_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic serial_in_pin, serial_out_pin, serial_out_oe_n, ext_clock_pin;
  logic handshake_in, handshake_out, handshake_oe_n, tx_irq, rx_irq;
  logic [15:0] got;
  int err_count, comparisons, tx_n, rx_n, k;

  asu_uart asu_uart_inst (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe_n(serial_out_oe_n), .ext_clock_pin(ext_clock_pin),
    .handshake_in(handshake_in), .handshake_out(handshake_out),
    .handshake_oe_n(handshake_oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq));
  asu_remote asu_remote_inst (.core_clk(core_clk), .tx_line(serial_out_pin),
    .rx_line(serial_in_pin));

  always @(posedge core_clk) begin
    if (tx_irq === 1'b1) tx_n <= tx_n + 1;
    if (rx_irq === 1'b1) rx_n <= rx_n + 1;
  end

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdata = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #200us;
    err_count++;
    print_verdict;
  end

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ext_clock_pin = 1'b0;
    handshake_in = 1'b0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    rd(OFF_MODE);
    `CHK(rdata, 32'h0)
    rd(OFF_CTRL0);
    `CHK(rdata, 32'h18)
    rd(OFF_CTRL1);
    `CHK(rdata, 32'h2)
    rd(8'h20);
    `CHK(last_err, 1'b1)
    `CHK(serial_out_pin, 1'b1)
    `CHK({handshake_oe_n, serial_out_oe_n}, 2'b10)
    $display("test reset done");
    // divider 0 at /1: one sample tick per clock, 16 clocks per bit
    wr(OFF_MODE, 32'h5);
    wr(OFF_CTRL1, 32'h1);
    wr(OFF_TXBUF, 32'ha5);
    asu_remote_inst.listen(10, got);
    `CHK(got[9:0], {1'b1, 8'ha5, 1'b0})
    `CHK(tx_n, 1)
    $display("test tx plain done");
    wr(OFF_MODE, 32'h75);
    wr(OFF_CTRL0, 32'h90);
    wr(OFF_CTRL1, 32'h11);
    wr(OFF_TXBUF, 32'h07);
    asu_remote_inst.listen(12, got);
    `CHK(got[11:0], {2'b11, 1'b1, 8'he0, 1'b0})
    repeat (8) @(posedge core_clk);
    `CHK(tx_n, 2)
    $display("test tx parity done");
    handshake_in <= 1'b1;
    wr(OFF_CTRL0, 32'h0);
    wr(OFF_MODE, 32'h6);
    wr(OFF_CTRL1, 32'h41);
    wr(OFF_TXBUF, 32'h10f);
    repeat (40) @(posedge core_clk);
    `CHK(serial_out_pin, 1'b1)
    handshake_in <= 1'b0;
    asu_remote_inst.listen(11, got);
    `CHK(got[10:0], {1'b1, 9'h0f0, 1'b0})
    // no edges on the external clock pin: the start bit must hold
    wr(OFF_MODE, 32'hd);
    wr(OFF_TXBUF, 32'hfe);
    repeat (64) @(posedge core_clk);
    `CHK(serial_out_pin, 1'b0)
    repeat (16) begin
      ext_clock_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      ext_clock_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
    `CHK(serial_out_pin, 1'b1)
    wr(OFF_MODE, 32'h5);
    repeat (200) @(posedge core_clk);
    $display("test tx options done");
    wr(OFF_CTRL0, 32'h10);
    wr(OFF_MODE, 32'h65);
    wr(OFF_CTRL1, 32'h4);
    asu_remote_inst.send({1'b1, 1'b0, 8'h3c, 1'b0}, 11);
    repeat (16) @(posedge core_clk);
    `CHK(rx_n, 1)
    rd(OFF_RXBUF);
    `CHK(rdata[15:0], 16'h003c)
    asu_remote_inst.send({1'b1, 1'b1, 8'h3c, 1'b0}, 11);
    repeat (16) @(posedge core_clk);
    rd(OFF_RXBUF);
    `CHK(rdata[15:0], 16'hc03c)
    wr(OFF_RXBUF, 32'h0);
    asu_remote_inst.send({1'b0, 1'b0, 8'h3c, 1'b0}, 11);
    repeat (40) @(posedge core_clk);
    rd(OFF_RXBUF);
    `CHK(rdata[15:13], 3'h5)
    wr(OFF_RXBUF, 32'h0);
    $display("test rx errors done");
    // second frame arrives while the first is still unread
    k = rx_n;
    asu_remote_inst.send({1'b1, 1'b0, 8'h3c, 1'b0}, 11);
    asu_remote_inst.send({1'b1, 1'b0, 8'h3c, 1'b0}, 11);
    repeat (16) @(posedge core_clk);
    `CHK(rx_n, k + 1)
    rd(OFF_RXBUF);
    `CHK({rdata[15], rdata[12]}, 2'b11)
    $display("test rx overrun done");
    wr(OFF_RXBUF, 32'h0);
    wr(OFF_MODE, 32'h14);
    wr(OFF_CTRL1, 32'hc4);
    asu_remote_inst.send({2'b11, 7'h2a, 1'b0}, 10);
    repeat (16) @(posedge core_clk);
    rd(OFF_RXBUF);
    `CHK(rdata[15:0], 16'h0055)
    wr(OFF_CTRL0, 32'h24);
    repeat (2) @(posedge core_clk);
    `CHK({handshake_oe_n, handshake_out}, 2'b00)
    `CHK(serial_out_oe_n, 1'b1)
    wr(OFF_CTRL1, 32'h0);
    wr(OFF_MODE, 32'h85);
    repeat (2) @(posedge core_clk);
    `CHK(handshake_out, 1'b1)
    `CHK({serial_out_pin, serial_out_oe_n}, 2'b00)
    $display("test rx options and pins done");
    print_verdict;
  end
endmodule
`default_nettype wire
